// [mtr_cfg.svh]
/*
 * Constants of the two-wire read path: bus address, counter reset, bit and page layout.
 * Assumes inclusion by the package and the top module only.
 */
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH
// ----------------------------------------
// Link framing
// ----------------------------------------
`define MTR_DEV_ADDR 7'h50
`define MTR_BIT_LAST 3'h7
`define MTR_BIT_STEP 3'h1
`define MTR_MSB 7
`define MTR_SYNC_IDLE 2'h3
// ----------------------------------------
// Byte address counter
// ----------------------------------------
`define MTR_CNT_RST 8'h00
`define MTR_PAGE_BIT 7
`define MTR_PAGE_LAST 7'h7f
`define MTR_PAGE_FIRST 7'h00
`define MTR_PTR_STEP 7'h01
`endif

// [mtr_pkg.sv]
/*
 * Types of the two-wire read path: states, carriers and the register struct.
 * Assumes mtr_cfg.svh beside it.
 */
`include "mtr_cfg.svh"
package mtr_pkg;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_CTRL = 9'h002,
        S_ACK = 9'h004,
        S_ADDR = 9'h008,
        S_WDATA = 9'h010,
        S_FETCH = 9'h020,
        S_RBIT = 9'h040,
        S_RACK = 9'h080,
        S_WAIT = 9'h100
    } mtr_fsm_t;

    typedef struct packed {
        logic [7:0] addr;
    } mtr_req_t;

    // Two bytes taken at one instant: addr and its page-wrapped successor
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } mtr_snap_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        mtr_fsm_t st;
        logic [2:0] bc;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic ack_on;
        logic nack;
        logic ok;
        logic [7:0] cnt;
        logic [7:0] ptr;
        mtr_snap_t snap;
        logic sv;
        logic si;
        logic req_v;
        logic pend;
        logic sda_oe_n;
        logic scl_oe_n;
    } mtr_regs_t;
endpackage

// [mtr_buf2.sv]
/*
 * Small FIFO, two entries by default, valid and ready on both sides.
 * Assumes a single clock; ce low freezes it and blocks both handshakes.
 */
`timescale 1ns/1ps
`default_nettype none
module mtr_buf2 #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LASTI = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] d;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } mtr_bst_t;

    mtr_bst_t r_ff, nxt_r;
    logic push, pop;

    assign in_ready = ce && (r_ff.cnt != FULL);
    assign out_valid = ce && (r_ff.cnt != '0);
    assign out_data = r_ff.d[r_ff.rp];
    assign push = in_valid && in_ready;
    assign pop = out_ready && out_valid;

    always_comb begin
        nxt_r = r_ff;
        if (push) begin
            nxt_r.d[r_ff.wp] = in_data;
            nxt_r.wp = (r_ff.wp == LASTI) ? '0 : r_ff.wp + AW'(1);
        end
        if (pop) begin
            nxt_r.rp = (r_ff.rp == LASTI) ? '0 : r_ff.rp + AW'(1);
        end
        if (push && !pop) begin
            nxt_r.cnt = r_ff.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_r.cnt = r_ff.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_ff <= '0;
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end
endmodule
`default_nettype wire

// [mtr_top.sv]
/*
 * Two-wire management slave, read path: control byte, dummy-write address load,
 * current address and sequential reads served from two-byte snapshots.
 * Assumes SCL and SDA arrive unsynchronised; memory answers one request with a
 * coherent pair of bytes through the small buffer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mtr_cfg.svh"
module mtr_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OE_N,
    output logic SCL_OE_N,
    output logic REQ_VALID,
    input wire logic REQ_READY,
    output mtr_pkg::mtr_req_t REQ,
    input wire logic MEM_VALID,
    output logic MEM_READY,
    input wire mtr_pkg::mtr_snap_t MEM,
    output logic [7:0] CNT
);
    import mtr_pkg::*;

    mtr_regs_t r_ff, nxt_r;
    logic scl, sda, rise, fall, start, stop;
    logic addr_done, adv, pop, b_valid;
    logic [7:0] byte_in, sel;
    logic [$bits(mtr_snap_t)-1:0] b_data;

    // Page wrap keeps the page bit, only the low seven bits count
    function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
        nxt_ptr = {p[`MTR_PAGE_BIT], p[`MTR_PAGE_BIT-1:0] + `MTR_PTR_STEP};
    endfunction

    mtr_buf2 #(.W($bits(mtr_snap_t)), .DEPTH(2)) u_buf (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(MEM_VALID),
        .in_ready(MEM_READY),
        .in_data(MEM),
        .out_valid(b_valid),
        .out_ready(pop),
        .out_data(b_data)
    );

    assign SDA_OE_N = r_ff.sda_oe_n;
    assign SCL_OE_N = r_ff.scl_oe_n;
    assign REQ_VALID = r_ff.req_v && CE;
    assign REQ.addr = r_ff.ptr;
    assign CNT = r_ff.cnt;

    // ----------------------------------------
    // Line events, from second and third sync stages only
    // ----------------------------------------
    assign scl = r_ff.s2[1];
    assign sda = r_ff.s2[0];
    assign rise = scl && !r_ff.s3[1];
    assign fall = !scl && r_ff.s3[1];
    assign start = scl && r_ff.s3[1] && r_ff.s3[0] && !sda;
    assign stop = scl && r_ff.s3[1] && !r_ff.s3[0] && sda;
    assign byte_in = {r_ff.sh[6:0], sda};
    assign sel = r_ff.si ? r_ff.snap.hi : r_ff.snap.lo;

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    always_comb begin
        nxt_r = r_ff;
        addr_done = 1'b0;
        adv = 1'b0;
        pop = 1'b0;
        nxt_r.s1 = {SCL, SDA_IN};
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        if (r_ff.req_v && REQ_READY) begin
            nxt_r.req_v = 1'b0;
        end
        if (start) begin
            // Abort drops pending advance; counter keeps any loaded address
            nxt_r.st = S_CTRL;
            nxt_r.bc = '0;
            nxt_r.ok = 1'b0;
            nxt_r.ptr = r_ff.cnt;
            nxt_r.sv = 1'b0;
            nxt_r.ack_on = 1'b0;
            nxt_r.sda_oe_n = 1'b1;
            nxt_r.scl_oe_n = 1'b1;
        end else if (stop) begin
            if (r_ff.ok) begin
                nxt_r.cnt = r_ff.ptr;
            end
            nxt_r.ok = 1'b0;
            nxt_r.st = S_IDLE;
            nxt_r.sda_oe_n = 1'b1;
            nxt_r.scl_oe_n = 1'b1;
        end else begin
            case (r_ff.st)
                S_CTRL, S_ADDR, S_WDATA: begin
                    if (rise) begin
                        nxt_r.sh = byte_in;
                        nxt_r.bc = r_ff.bc + `MTR_BIT_STEP;
                        if (r_ff.bc == `MTR_BIT_LAST) begin
                            nxt_r.st = S_ACK;
                            if (r_ff.st == S_CTRL) begin
                                if (byte_in[7:1] == `MTR_DEV_ADDR) begin
                                    nxt_r.rw = byte_in[0];
                                    nxt_r.first = !byte_in[0];
                                end else begin
                                    nxt_r.st = S_IDLE;
                                end
                            end else if (r_ff.st == S_ADDR) begin
                                addr_done = 1'b1;
                                nxt_r.cnt = byte_in;
                                nxt_r.ptr = byte_in;
                                nxt_r.first = 1'b0;
                                nxt_r.sv = 1'b0;
                            end else begin
                                // Write data is outside this path: only counted
                                adv = 1'b1;
                                nxt_r.ptr = nxt_ptr(r_ff.ptr);
                                nxt_r.ok = 1'b1;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        if (!r_ff.ack_on) begin
                            nxt_r.ack_on = 1'b1;
                            nxt_r.sda_oe_n = 1'b0;
                        end else begin
                            nxt_r.ack_on = 1'b0;
                            nxt_r.sda_oe_n = 1'b1;
                            nxt_r.bc = '0;
                            if (r_ff.rw) begin
                                nxt_r.st = S_FETCH;
                                nxt_r.scl_oe_n = 1'b0;
                            end else if (r_ff.first) begin
                                nxt_r.st = S_ADDR;
                            end else begin
                                nxt_r.st = S_WDATA;
                            end
                        end
                    end
                end
                S_FETCH: begin
                    // SCL held low until a byte of the snapshot is at hand
                    if (r_ff.sv) begin
                        nxt_r.sh = sel;
                        nxt_r.sda_oe_n = sel[`MTR_MSB];
                        nxt_r.scl_oe_n = 1'b1;
                        nxt_r.st = S_RBIT;
                        nxt_r.si = 1'b1;
                        // Pair used up: a third byte gets a fresh pair, so
                        // nothing longer than two bytes is coherent
                        nxt_r.sv = !r_ff.si;
                    end else if (b_valid && r_ff.pend) begin
                        pop = 1'b1;
                        nxt_r.snap = mtr_snap_t'(b_data);
                        nxt_r.sv = 1'b1;
                        nxt_r.si = 1'b0;
                        nxt_r.pend = 1'b0;
                    end else if (!r_ff.pend) begin
                        nxt_r.req_v = 1'b1;
                        nxt_r.pend = 1'b1;
                    end
                end
                S_RBIT: begin
                    if (fall) begin
                        if (r_ff.bc == `MTR_BIT_LAST) begin
                            nxt_r.st = S_RACK;
                            nxt_r.sda_oe_n = 1'b1;
                            adv = 1'b1;
                            nxt_r.ptr = nxt_ptr(r_ff.ptr);
                            nxt_r.ok = 1'b1;
                        end else begin
                            nxt_r.bc = r_ff.bc + `MTR_BIT_STEP;
                            nxt_r.sh = {r_ff.sh[6:0], 1'b0};
                            nxt_r.sda_oe_n = r_ff.sh[6];
                        end
                    end
                end
                S_RACK: begin
                    if (rise) begin
                        nxt_r.nack = sda;
                    end
                    if (fall) begin
                        nxt_r.bc = '0;
                        if (r_ff.nack) begin
                            nxt_r.st = S_WAIT;
                        end else begin
                            nxt_r.st = S_FETCH;
                            nxt_r.scl_oe_n = 1'b0;
                        end
                    end
                end
                default: begin
                    nxt_r.st = r_ff.st;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r_ff <= '0;
            r_ff.st <= S_IDLE;
            r_ff.s1 <= `MTR_SYNC_IDLE;
            r_ff.s2 <= `MTR_SYNC_IDLE;
            r_ff.s3 <= `MTR_SYNC_IDLE;
            r_ff.cnt <= `MTR_CNT_RST;
            r_ff.sda_oe_n <= 1'b1;
            r_ff.scl_oe_n <= 1'b1;
        end else if (CE) begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_ctrl_hit;
        CE && r_ff.st == S_CTRL && rise && r_ff.bc == `MTR_BIT_LAST && byte_in[7:1] == `MTR_DEV_ADDR;
    endsequence
    sequence s_ack_drive;
        CE && r_ff.st == S_ACK && !r_ff.ack_on && fall;
    endsequence
    sequence s_stop_ok;
        CE && stop && r_ff.ok;
    endsequence

    // A matching control byte must lead into the acknowledge slot, line still released
    AST_CTRL_ACK: assert property (s_ctrl_hit |=> r_ff.st == S_ACK && !r_ff.ack_on && SDA_OE_N)
        else $error("control byte not taken to acknowledge");
    AST_ACK_LOW: assert property (s_ack_drive |=> !SDA_OE_N && r_ff.ack_on)
        else $error("ack slot not driven low");
    AST_STRETCH: assert property (r_ff.st == S_FETCH |-> !SCL_OE_N)
        else $error("SCL released before data ready");
    AST_SNAP: assert property (CE && r_ff.st == S_FETCH && r_ff.sv && !start && !stop
        |=> r_ff.sh == ($past(r_ff.si) ? $past(r_ff.snap.hi) : $past(r_ff.snap.lo)))
        else $error("byte not from snapshot");
    AST_COMMIT: assert property (s_stop_ok |=> r_ff.cnt == $past(r_ff.ptr) && r_ff.st == S_IDLE)
        else $error("counter not advanced at stop");
    AST_ABORT: assert property (CE && start |=> r_ff.cnt == $past(r_ff.cnt) && r_ff.ptr == $past(r_ff.cnt))
        else $error("abort changed counter");
    AST_LOAD: assert property (CE && addr_done |=> r_ff.cnt == $past(byte_in))
        else $error("address byte not loaded");
    AST_WRAP: assert property (CE && adv && r_ff.ptr[6:0] == `MTR_PAGE_LAST
        |=> r_ff.ptr == {$past(r_ff.ptr[7]), `MTR_PAGE_FIRST})
        else $error("page wrap wrong");
    AST_MSB: assert property (CE && r_ff.st == S_RBIT && fall && r_ff.bc != `MTR_BIT_LAST
        && !start && !stop |=> SDA_OE_N == $past(r_ff.sh[6]))
        else $error("bit order wrong");
    AST_CNT_HOLD: assert property (CE && !addr_done && !(stop && r_ff.ok) |=> $stable(r_ff.cnt))
        else $error("counter moved without cause");
endmodule
`default_nettype wire

// [mtr_host_model.sv]
/*
 * Host master model of the two-wire link: START, STOP, byte send and receive.
 * Assumes the bench wire-ANDs SCL and SDA, with a pull-up on SDA.
 */
`timescale 1ns/1ps
`default_nettype none
module mtr_host_model (
    output logic scl_drv,
    output logic sda_pull,
    input wire logic scl_w,
    input wire logic sda_w
);
    // ----------------------------------------
    // Bit level, 80 ns per bit
    // ----------------------------------------
    initial begin
        scl_drv = 1'b1;
        sda_pull = 1'b0;
    end

    // SDA moves only while SCL is low; the rise waits out a stretch
    task automatic bit_xfer(input logic b, output logic r);
        int n;
        #20 sda_pull = ~b;
        #20 scl_drv = 1'b1;
        for (n = 0; n < 1000 && scl_w !== 1'b1; n++) #10;
        #20 r = sda_w;
        #20 scl_drv = 1'b0;
    endtask

    // ----------------------------------------
    // Frame level
    // ----------------------------------------
    // Late release lets the slave drop its ACK before SCL rises
    task automatic send_start();
        #33.3 sda_pull = 1'b0;
        #30 scl_drv = 1'b1;
        #40 sda_pull = 1'b1;
        #40 scl_drv = 1'b0;
    endtask

    task automatic send_stop();
        #30 sda_pull = 1'b1;
        #30 scl_drv = 1'b1;
        #40 sda_pull = 1'b0;
        #40;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // Two-byte entities are fetched by one sequential read
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// [module_twi_read_operations_tb_top.sv]
/*
 * Bench of the two-wire read path: host model, memory model and scenarios.
 * Assumes mtr_pkg, mtr_buf2, mtr_top and mtr_host_model compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module module_twi_read_operations_tb_top;
    import mtr_pkg::*;
    logic CLK, RST, CE, REQ_READY, MEM_VALID, SDA_OE_N, SCL_OE_N, REQ_VALID, MEM_READY;
    mtr_req_t REQ;
    mtr_snap_t MEM;
    logic [7:0] CNT;
    logic host_scl, host_pull, scl_w, sda_w;
    logic [7:0] mem [256];
    logic [7:0] cur, req_a;
    int miscompares = 0;
    int checked = 0;
    int req_lat = 0;
    int mem_lat = 1;

    assign scl_w = host_scl & SCL_OE_N;
    assign sda_w = ~host_pull & SDA_OE_N;

    mtr_top dut_u (.CLK(CLK), .RST(RST), .CE(CE), .SCL(scl_w), .SDA_IN(sda_w), .SDA_OE_N(SDA_OE_N),
        .SCL_OE_N(SCL_OE_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
        .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY), .MEM(MEM), .CNT(CNT));
    mtr_host_model host_u (.scl_drv(host_scl), .sda_pull(host_pull), .scl_w(scl_w), .sda_w(sda_w));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // ----------------------------------------
    // Memory model
    // ----------------------------------------
    function automatic logic [7:0] succ(input logic [7:0] a);
        return {a[7], a[6:0] + 7'h01};
    endfunction

    // Pair taken at one instant; lines inverted once released
    always begin
        @(posedge CLK);
        #1;
        if (REQ_VALID === 1'b1) begin
            repeat (req_lat) @(posedge CLK);
            #1 REQ_READY = 1'b1;
            req_a = REQ.addr;
            @(posedge CLK);
            #1 REQ_READY = 1'b0;
            repeat (mem_lat) @(posedge CLK);
            #1 MEM = {mem[succ(req_a)], mem[req_a]};
            MEM_VALID = 1'b1;
            while (MEM_READY !== 1'b1) begin
                @(posedge CLK);
                #1;
            end
            @(posedge CLK);
            #1 MEM_VALID = 1'b0;
            MEM = ~MEM;
        end
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (10) @(posedge CLK);
        #1;
    endtask

    // ----------------------------------------
    // Frame helpers
    // ----------------------------------------
    task automatic ctrl(input logic [7:0] b, input logic exp_ack);
        logic ack;
        host_u.send_start();
        host_u.send_byte(b, ack);
        check("control ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask

    task automatic load_addr(input logic [7:0] a);
        logic ack;
        ctrl(8'ha0, 1'b1);
        host_u.send_byte(a, ack);
        check("address ack", {7'h00, ack}, 8'h01);
        check("loaded counter", CNT, a);
        ctrl(8'ha1, 1'b1);
        check("counter after restart", CNT, a);
        cur = a;
    endtask

    // Poke alters the next byte in memory once the previous one is out
    task automatic read_bytes(input int n, input logic poke);
        logic [7:0] d, exp;
        exp = mem[cur];
        for (int i = 0; i < n; i++) begin
            host_u.recv_byte(i == n - 1, d);
            check("read byte", d, exp);
            cur = succ(cur);
            exp = mem[cur];
            if (poke) mem[cur] = ~exp;
        end
        host_u.send_stop();
        settle();
        check("counter after stop", CNT, cur);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("idle pins", {5'h00, SDA_OE_N, SCL_OE_N, REQ_VALID}, 8'h06);
        check("counter reset", CNT, 8'h00);
    endtask

    task automatic t_random();
        logic [7:0] addrs [3] = '{8'h10, 8'h7f, 8'hff};
        foreach (addrs[i]) begin
            load_addr(addrs[i]);
            read_bytes(1, 1'b0);
        end
    endtask

    task automatic t_current();
        ctrl(8'ha1, 1'b1);
        read_bytes(1, 1'b0);
    endtask

    // Slow memory; second byte of the pair changed in memory mid-read
    task automatic t_pair();
        req_lat = 4;
        mem_lat = 6;
        load_addr(8'h7f);
        read_bytes(2, 1'b1);
        load_addr(8'h20);
        read_bytes(3, 1'b0);
        req_lat = 0;
        mem_lat = 1;
    endtask

    task automatic t_refuse();
        ctrl(8'ha2, 1'b0);
        host_u.send_stop();
        settle();
        check("counter after refusal", CNT, cur);
    endtask

    // Read cut by a START instead of STOP leaves the counter alone
    task automatic t_abort();
        logic [7:0] d;
        ctrl(8'ha1, 1'b1);
        host_u.recv_byte(1'b1, d);
        check("aborted byte", d, mem[cur]);
        host_u.send_start();
        host_u.send_stop();
        settle();
        check("counter after abort", CNT, cur);
    endtask

    // Frozen block holds its counter and blocks both memory handshakes; mid-run reset clears it
    task automatic t_hold();
        CE = 1'b0;
        settle();
        check("frozen handshakes", {6'h00, REQ_VALID, MEM_READY}, 8'h00);
        check("frozen counter", CNT, cur);
        CE = 1'b1;
        RST = 1'b1;
        repeat (2) @(posedge CLK);
        #1 RST = 1'b0;
        settle();
        check("pins after reset", {5'h00, SDA_OE_N, SCL_OE_N, REQ_VALID}, 8'h06);
        check("counter after reset", CNT, 8'h00);
        check("buffer ready after reset", {7'h00, MEM_READY}, 8'h01);
        cur = 8'h00;
    endtask

    initial begin
        RST = 1'b1;
        CE = 1'b1;
        REQ_READY = 1'b0;
        MEM_VALID = 1'b0;
        MEM = '0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        repeat (12) @(posedge CLK);
        #1 RST = 1'b0;
        repeat (6) @(posedge CLK);
        #1;
        t_reset();
        t_random();
        t_current();
        t_pair();
        t_refuse();
        t_abort();
        t_hold();
        t_current();
        finish_test();
    end

    // Whole run needs well under half of this span
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
